// ===== rtl/brs_pkg.sv
// Constants for the converter settings register block
// Functional notes
// - With auto-return set, page select returns to 000 after each finished access.
// - Bit 6 of page control: 0 page write, 1 repeated write on two-wire.
// - Two-wire: page 00x reaches 0x00-0xFF, 01x reaches 0x100-0x17F.
// - SPI: pages 000/001/010 reach 0x00/0x80/0x100 blocks; higher codes are reserved.
// - Current limit codes: B bits 7:4, A bits 3:0; 4000 mA plus 200 mA steps.
// - A power-down ramp bits 7:5 select 1.25 to 40 mV/us; 111 means no ramp.
// - A start-up ramp bits 4:2 same rates; 111 applies target immediately.
// - Mode bits 1:0: 00 set by voltage registers, 01/11 automatic, 10 forced PWM.
// - Converter B configuration register has identical fields and encodings.
// - Bit 4 enables phase shedding for B, bit 3 for A.
// - B phase count bit 2: 0 one phase, 1 two phases.
// - A phase field 1:0 selects 1-4 phases; above two only on four-phase variant.
// - A voltage ceiling bits 6:0 read-only from one-time memory; 0.30 V plus 10 mV steps.
`default_nettype none
package brs_pkg;
  // Full register addresses
  localparam logic [8:0] OFS_PAGE_CONTROL = 9'h080;
  localparam logic [8:0] OFS_ILIM         = 9'h0d0;
  localparam logic [8:0] OFS_CONV_A       = 9'h0d1;
  localparam logic [8:0] OFS_CONV_B       = 9'h0d2;
  localparam logic [8:0] OFS_PHASE        = 9'h0d3;
  localparam logic [8:0] OFS_VCEIL_A      = 9'h0d5;
  // Upper region base and page codes
  localparam logic [8:0] OFS_UPPER_BASE   = 9'h100;
  localparam logic [2:0] PAGE_ZERO        = 3'h0;
  localparam logic [2:0] PAGE_SPI_MAX     = 3'h2;
  // Page control fields
  localparam int POS_AUTO_RETURN = 7;
  localparam int POS_WRITE_STYLE = 6;
  // Configuration fields
  localparam int POS_FALLOFF  = 5;
  localparam int POS_RISE     = 2;
  localparam int POS_MODE     = 0;
  localparam int POS_ILIM_B   = 4;
  localparam int POS_ILIM_A   = 0;
  localparam int POS_SHED_B   = 4;
  localparam int POS_SHED_A   = 3;
  localparam int POS_PHASE_B  = 2;
  localparam int POS_PHASE_A  = 0;
  // Encodings
  localparam logic [2:0] RAMP_NONE     = 3'h7;
  localparam logic [1:0] MODE_BY_VREG  = 2'h0;
  localparam logic [1:0] MODE_PWM      = 2'h2;
  localparam logic [1:0] PHASE_TWO     = 2'h1;
  // Scaled values
  localparam logic [12:0] ILIM_BASE_MA  = 13'h0fa0;
  localparam logic [12:0] ILIM_STEP_MA  = 13'h00c8;
  localparam logic [10:0] VCEIL_BASE_MV = 11'h12c;
  localparam logic [10:0] VCEIL_STEP_MV = 11'h00a;
  // Values after reset
  localparam logic [7:0] RST_PAGE_CONTROL = 8'h00;
  localparam logic [7:0] RST_ILIM         = 8'h00;
  localparam logic [7:0] RST_CONV         = 8'h00;
  localparam logic [7:0] RST_PHASE        = 8'h00;
endpackage
`default_nettype wire

// ===== rtl/brs_page_map.sv
// Link address to full register address translation per page
`default_nettype none
module brs_page_map (
  // Page and link mode
  input  wire logic [2:0] page,
  input  wire logic       spi_mode,
  // Address as seen on the link
  input  wire logic [7:0] link_addr,
  // Translated address
  output logic      [8:0] full_addr,
  output logic            mapped
);
  // Translation; reserved pages map nowhere so they cannot disturb settings
  always_comb begin
    full_addr = 9'h000;
    mapped    = 1'b0;
    if (spi_mode) begin
      if (page <= brs_pkg::PAGE_SPI_MAX) begin
        full_addr = {page[1:0], link_addr[6:0]};
        mapped    = 1'b1;
      end
    end else if (page[2] == 1'b0) begin
      if (page[1] == 1'b0) begin
        full_addr = {1'b0, link_addr};
        mapped    = 1'b1;
      end else if (link_addr[7] == 1'b0) begin
        full_addr = brs_pkg::OFS_UPPER_BASE | {2'h0, link_addr[6:0]};
        mapped    = 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== rtl/brs_regs.sv
// Converter settings registers with page selection, top level
`default_nettype none
module brs_regs #(
  parameter int FOUR_PHASE = 0
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  // Byte access from the link front end
  input  wire logic        acc_valid,
  input  wire logic        acc_write,
  input  wire logic        acc_seq,
  input  wire logic [7:0]  acc_addr,
  input  wire logic [7:0]  acc_wdata,
  input  wire logic        acc_spi,
  input  wire logic        acc_done,
  // One-time memory value
  input  wire logic [6:0]  otp_vceil_a,
  // Read answer
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic             rd_hit,
  // Page state
  output logic      [2:0]  reg_page,
  output logic             repeated_write,
  // Converter A controls
  output logic      [3:0]  conv_a_current_cap,
  output logic      [12:0] conv_a_ilim_ma,
  output logic      [7:0]  conv_a_fall_qmv,
  output logic             conv_a_fall_off,
  output logic      [7:0]  conv_a_rise_qmv,
  output logic             conv_a_rise_instant,
  output logic             conv_a_force_pwm,
  output logic             conv_a_by_vreg,
  output logic             conv_a_shedding_on,
  output logic      [1:0]  conv_a_phases_eff,
  output logic      [10:0] conv_a_vceil_mv,
  // Converter B controls
  output logic      [3:0]  conv_b_current_cap,
  output logic      [12:0] conv_b_ilim_ma,
  output logic      [7:0]  conv_b_fall_qmv,
  output logic             conv_b_fall_off,
  output logic      [7:0]  conv_b_rise_qmv,
  output logic             conv_b_rise_instant,
  output logic             conv_b_force_pwm,
  output logic             conv_b_by_vreg,
  output logic             conv_b_shedding_on,
  output logic             conv_b_two_phase
);
  // Variant check, refused at elaboration
  if (FOUR_PHASE != 0 && FOUR_PHASE != 1) begin : g_bad_variant
    $error("FOUR_PHASE must be 0 or 1");
  end

  typedef struct packed {
    // Register contents
    logic [7:0]  page_ctl;
    logic [7:0]  ilim;
    logic [7:0]  conf_a;
    logic [7:0]  conf_b;
    logic [7:0]  phase;
    logic [6:0]  vceil;
    // Access tracking and read answer
    logic [8:0]  last_addr;
    logic        last_ok;
    logic [7:0]  rd_data;
    logic        rd_valid;
    logic        rd_hit;
    // Decoded controls, kept in flops
    logic [12:0] ilim_a_ma;
    logic [12:0] ilim_b_ma;
    logic [7:0]  fall_a;
    logic [7:0]  rise_a;
    logic [7:0]  fall_b;
    logic [7:0]  rise_b;
    logic [1:0]  phases_a;
    logic [10:0] vceil_mv;
    logic        fall_off_a;
    logic        rise_inst_a;
    logic        force_pwm_a;
    logic        by_vreg_a;
    logic        fall_off_b;
    logic        rise_inst_b;
    logic        force_pwm_b;
    logic        by_vreg_b;
  } brs_state_t;

  brs_state_t st_r;
  brs_state_t st_nxt;
  logic [8:0] map_addr;
  logic       map_ok;
  logic [8:0] eff_addr;
  logic       eff_ok;

  // Ramp rate in quarter mV/us; 111 gives zero
  function automatic logic [7:0] ramp_qmv(input logic [2:0] code);
    logic [7:0] r;
    r = 8'h00;
    case (code)
      3'h0:    r = 8'h05;
      3'h1:    r = 8'h0a;
      3'h2:    r = 8'h14;
      3'h3:    r = 8'h28;
      3'h4:    r = 8'h50;
      3'h5:    r = 8'h78;
      3'h6:    r = 8'ha0;
      default: r = 8'h00;
    endcase
    return r;
  endfunction

  // Code times step; the product never exceeds 13 bits for a 4-bit code
  function automatic logic [12:0] ilim_mul(input logic [3:0] code);
    logic [16:0] w;
    w = {13'h0000, code} * {4'h0, brs_pkg::ILIM_STEP_MA};
    return w[12:0];
  endfunction

  // Per-phase current limit in mA
  function automatic logic [12:0] ilim_ma(input logic [3:0] code);
    logic [12:0] p;
    p = ilim_mul(code);
    return brs_pkg::ILIM_BASE_MA + p;
  endfunction

  // Ramp code 111 stops the ramp: no ramped fall, or an instant rise
  function automatic logic ramp_stops(input logic [2:0] code);
    return code == brs_pkg::RAMP_NONE;
  endfunction

  // Mode decode as {force PWM, set by voltage registers}; 01 and 11 give automatic
  function automatic logic [1:0] mode_flags(input logic [1:0] mode);
    logic [1:0] f;
    f = {mode == brs_pkg::MODE_PWM, mode == brs_pkg::MODE_BY_VREG};
    return f;
  endfunction

  // Phase count limited by the variant
  function automatic logic [1:0] phase_limit(input logic [1:0] code);
    logic [1:0] p;
    p = code;
    if (FOUR_PHASE == 0 && code > brs_pkg::PHASE_TWO) begin
      p = brs_pkg::PHASE_TWO;
    end
    return p;
  endfunction

  // Address translation by page
  brs_page_map u_map (
    .page      (st_r.page_ctl[2:0]),
    .spi_mode  (acc_spi),
    .link_addr (acc_addr),
    .full_addr (map_addr),
    .mapped    (map_ok)
  );

  // Continuation bytes follow the previous address; repeated style refuses them on two-wire
  always_comb begin
    eff_addr = map_addr;
    eff_ok   = map_ok;
    if (acc_seq) begin
      eff_addr = st_r.last_addr + 9'h001;
      eff_ok   = st_r.last_ok && (acc_spi || !st_r.page_ctl[brs_pkg::POS_WRITE_STYLE]);
    end
  end

  // Next state: access, auto-return, then derived outputs
  always_comb begin
    st_nxt          = st_r;
    st_nxt.rd_valid = 1'b0;
    // Ceiling is not writable; follows the one-time memory value
    st_nxt.vceil    = otp_vceil_a;
    if (acc_valid) begin
      st_nxt.last_addr = eff_addr;
      st_nxt.last_ok   = eff_ok;
      // Writes land only on mapped addresses of this block
      if (acc_write && eff_ok) begin
        case (eff_addr)
          brs_pkg::OFS_PAGE_CONTROL: st_nxt.page_ctl = {acc_wdata[7:6], 3'h0, acc_wdata[2:0]};
          brs_pkg::OFS_ILIM:         st_nxt.ilim = acc_wdata;
          brs_pkg::OFS_CONV_A:       st_nxt.conf_a = acc_wdata;
          brs_pkg::OFS_CONV_B:       st_nxt.conf_b = acc_wdata;
          brs_pkg::OFS_PHASE:        st_nxt.phase = {3'h0, acc_wdata[4:0]};
          default:                   st_nxt.rd_hit = st_r.rd_hit;
        endcase
      end
      // Reads answer once; unmapped or foreign addresses give zero and no hit
      if (!acc_write) begin
        st_nxt.rd_valid = 1'b1;
        st_nxt.rd_hit   = eff_ok;
        st_nxt.rd_data  = 8'h00;
        if (eff_ok) begin
          case (eff_addr)
            brs_pkg::OFS_PAGE_CONTROL: st_nxt.rd_data = st_r.page_ctl;
            brs_pkg::OFS_ILIM:         st_nxt.rd_data = st_r.ilim;
            brs_pkg::OFS_CONV_A:       st_nxt.rd_data = st_r.conf_a;
            brs_pkg::OFS_CONV_B:       st_nxt.rd_data = st_r.conf_b;
            brs_pkg::OFS_PHASE:        st_nxt.rd_data = st_r.phase;
            brs_pkg::OFS_VCEIL_A:      st_nxt.rd_data = {1'b0, st_r.vceil};
            default: begin
              st_nxt.rd_data = 8'h00;
              st_nxt.rd_hit  = 1'b0;
            end
          endcase
        end
      end
    end

    // Access finished: page goes back to zero when asked
    if (acc_done && st_nxt.page_ctl[brs_pkg::POS_AUTO_RETURN]) begin
      st_nxt.page_ctl[2:0] = brs_pkg::PAGE_ZERO;
    end

    // Decoded values, registered so outputs come straight from flops
    st_nxt.ilim_a_ma = ilim_ma(st_nxt.ilim[brs_pkg::POS_ILIM_A +: 4]);
    st_nxt.ilim_b_ma = ilim_ma(st_nxt.ilim[brs_pkg::POS_ILIM_B +: 4]);
    st_nxt.fall_a    = ramp_qmv(st_nxt.conf_a[brs_pkg::POS_FALLOFF +: 3]);
    st_nxt.rise_a    = ramp_qmv(st_nxt.conf_a[brs_pkg::POS_RISE +: 3]);
    st_nxt.fall_b    = ramp_qmv(st_nxt.conf_b[brs_pkg::POS_FALLOFF +: 3]);
    st_nxt.rise_b    = ramp_qmv(st_nxt.conf_b[brs_pkg::POS_RISE +: 3]);
    st_nxt.phases_a  = phase_limit(st_nxt.phase[brs_pkg::POS_PHASE_A +: 2]);
    st_nxt.vceil_mv  = brs_pkg::VCEIL_BASE_MV
                     + 11'({4'h0, st_nxt.vceil} * brs_pkg::VCEIL_STEP_MV);

    // Ramp stop and mode flags, registered for the same reason
    st_nxt.fall_off_a  = ramp_stops(st_nxt.conf_a[brs_pkg::POS_FALLOFF +: 3]);
    st_nxt.rise_inst_a = ramp_stops(st_nxt.conf_a[brs_pkg::POS_RISE +: 3]);
    st_nxt.fall_off_b  = ramp_stops(st_nxt.conf_b[brs_pkg::POS_FALLOFF +: 3]);
    st_nxt.rise_inst_b = ramp_stops(st_nxt.conf_b[brs_pkg::POS_RISE +: 3]);
    {st_nxt.force_pwm_a, st_nxt.by_vreg_a} =
      mode_flags(st_nxt.conf_a[brs_pkg::POS_MODE +: 2]);
    {st_nxt.force_pwm_b, st_nxt.by_vreg_b} =
      mode_flags(st_nxt.conf_b[brs_pkg::POS_MODE +: 2]);
  end

  // State register; decoded resets match the all-zero settings
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_r.page_ctl    <= brs_pkg::RST_PAGE_CONTROL;
      st_r.ilim        <= brs_pkg::RST_ILIM;
      st_r.conf_a      <= brs_pkg::RST_CONV;
      st_r.conf_b      <= brs_pkg::RST_CONV;
      st_r.phase       <= brs_pkg::RST_PHASE;
      st_r.vceil       <= 7'h00;
      st_r.last_addr   <= 9'h000;
      st_r.last_ok     <= 1'b0;
      st_r.rd_data     <= 8'h00;
      st_r.rd_valid    <= 1'b0;
      st_r.rd_hit      <= 1'b0;
      st_r.ilim_a_ma   <= brs_pkg::ILIM_BASE_MA;
      st_r.ilim_b_ma   <= brs_pkg::ILIM_BASE_MA;
      st_r.fall_a      <= 8'h05;
      st_r.rise_a      <= 8'h05;
      st_r.fall_b      <= 8'h05;
      st_r.rise_b      <= 8'h05;
      st_r.phases_a    <= 2'h0;
      st_r.vceil_mv    <= brs_pkg::VCEIL_BASE_MV;
      st_r.fall_off_a  <= 1'b0;
      st_r.rise_inst_a <= 1'b0;
      st_r.fall_off_b  <= 1'b0;
      st_r.rise_inst_b <= 1'b0;
      st_r.force_pwm_a <= 1'b0;
      st_r.force_pwm_b <= 1'b0;
      st_r.by_vreg_a   <= 1'b1;
      st_r.by_vreg_b   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs are flop bits of the state
  assign rd_data             = st_r.rd_data;
  assign rd_valid            = st_r.rd_valid;
  assign rd_hit              = st_r.rd_hit;
  assign reg_page            = st_r.page_ctl[2:0];
  assign repeated_write      = st_r.page_ctl[brs_pkg::POS_WRITE_STYLE];
  // Current limits and ramp rates
  assign conv_a_current_cap  = st_r.ilim[brs_pkg::POS_ILIM_A +: 4];
  assign conv_b_current_cap  = st_r.ilim[brs_pkg::POS_ILIM_B +: 4];
  assign conv_a_ilim_ma      = st_r.ilim_a_ma;
  assign conv_b_ilim_ma      = st_r.ilim_b_ma;
  assign conv_a_fall_qmv     = st_r.fall_a;
  assign conv_a_rise_qmv     = st_r.rise_a;
  assign conv_b_fall_qmv     = st_r.fall_b;
  assign conv_b_rise_qmv     = st_r.rise_b;
  // A ramp stop stands only for code 111
  assign conv_a_fall_off     = st_r.fall_off_a;
  assign conv_a_rise_instant = st_r.rise_inst_a;
  assign conv_b_fall_off     = st_r.fall_off_b;
  assign conv_b_rise_instant = st_r.rise_inst_b;
  // Modes 01 and 11 both leave the converter automatic
  assign conv_a_force_pwm    = st_r.force_pwm_a;
  assign conv_a_by_vreg      = st_r.by_vreg_a;
  assign conv_b_force_pwm    = st_r.force_pwm_b;
  assign conv_b_by_vreg      = st_r.by_vreg_b;
  // Phase shedding, phase counts and voltage ceiling
  assign conv_a_shedding_on  = st_r.phase[brs_pkg::POS_SHED_A];
  assign conv_b_shedding_on  = st_r.phase[brs_pkg::POS_SHED_B];
  assign conv_b_two_phase    = st_r.phase[brs_pkg::POS_PHASE_B];
  assign conv_a_phases_eff   = st_r.phases_a;
  assign conv_a_vceil_mv     = st_r.vceil_mv;
endmodule
`default_nettype wire

// ===== verif/brs_regs_sva.sv
// Port assertions for the converter settings register block
`default_nettype none
module brs_regs_sva #(
  parameter int FOUR_PHASE = 0
) (
  // Clock, reset and byte access
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        acc_valid,
  input wire logic        acc_write,
  input wire logic        acc_seq,
  input wire logic [7:0]  acc_addr,
  input wire logic [7:0]  acc_wdata,
  input wire logic        acc_spi,
  input wire logic        acc_done,
  // Read answer and page state
  input wire logic [7:0]  rd_data,
  input wire logic        rd_hit,
  input wire logic [2:0]  reg_page,
  input wire logic        repeated_write,
  // Converter controls
  input wire logic [3:0]  conv_a_current_cap,
  input wire logic [12:0] conv_a_ilim_ma,
  input wire logic        conv_a_fall_off,
  input wire logic        conv_a_rise_instant,
  input wire logic        conv_a_force_pwm,
  input wire logic        conv_a_by_vreg,
  input wire logic        conv_a_shedding_on,
  input wire logic [1:0]  conv_a_phases_eff,
  input wire logic        conv_b_shedding_on,
  input wire logic        conv_b_two_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       w0, w1, rq, auto_r;
  logic [7:0] wa, wd_r;
  // Plain writes via two-wire page 00x or SPI page 001; wa is zero when idle
  assign w0 = acc_valid && acc_write && !acc_seq && !acc_spi && reg_page[2:1] == 2'h0;
  assign w1 = acc_valid && acc_write && !acc_seq && acc_spi && reg_page == 3'h1;
  assign rq = acc_valid && !acc_write && !acc_seq;
  assign wa = w0 ? acc_addr : 8'h00;
  // Shadow of the auto-return bit, and the last data byte
  always_ff @(posedge mclk or negedge resetn)
    if (!resetn) begin
      auto_r <= 1'b0;
      wd_r   <= 8'h00;
    end else begin
      wd_r <= acc_wdata;
      if (wa == 8'h80 || (w1 && acc_addr[6:0] == 7'h00)) auto_r <= acc_wdata[7];
    end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  chk_page_return: assert property (acc_done && auto_r && !acc_valid |=> reg_page == 3'h0)
    else $error("page kept after finished access");
  chk_write_style: assert property (wa == 8'h80 |=> repeated_write == wd_r[6])
    else $error("write style bit misplaced");
  chk_upper_refuse: assert property (rq && !acc_spi && reg_page[2:1] == 2'h1 && acc_addr[7]
    |=> !rd_hit && rd_data == 8'h00) else $error("upper page high address answered");
  chk_spi_reserved: assert property (rq && acc_spi && reg_page > 3'h2 |=> !rd_hit)
    else $error("reserved page answered");
  chk_ilim_scale: assert property (conv_a_ilim_ma == 13'h0fa0 + 13'h00c8 * conv_a_current_cap)
    else $error("current limit scale");
  chk_ramp_codes: assert property (wa == 8'hd1 |=>
    conv_a_fall_off == &wd_r[7:5] && conv_a_rise_instant == &wd_r[4:2])
    else $error("ramp code 111 misread");
  chk_mode_decode: assert property (wa == 8'hd1 |=>
    conv_a_force_pwm == (wd_r[1:0] == 2'h2) && conv_a_by_vreg == (wd_r[1:0] == 2'h0))
    else $error("mode decode");
  chk_shed_phase: assert property (wa == 8'hd3 |=>
    {conv_b_shedding_on, conv_a_shedding_on, conv_b_two_phase} == wd_r[4:2])
    else $error("shedding or phase bit misplaced");
  chk_phase_clamp: assert property (wa == 8'hd3 |=> conv_a_phases_eff ==
    (FOUR_PHASE == 0 && wd_r[1] ? 2'h1 : wd_r[1:0])) else $error("phase count clamp");
endmodule
bind brs_regs brs_regs_sva #(.FOUR_PHASE(FOUR_PHASE)) chk_u (.mclk, .resetn, .acc_valid,
  .acc_write, .acc_seq, .acc_addr, .acc_wdata, .acc_spi, .acc_done, .rd_data, .rd_hit, .reg_page,
  .repeated_write, .conv_a_current_cap, .conv_a_ilim_ma, .conv_a_fall_off, .conv_a_rise_instant,
  .conv_a_force_pwm, .conv_a_by_vreg, .conv_a_shedding_on, .conv_a_phases_eff,
  .conv_b_shedding_on, .conv_b_two_phase);
`default_nettype wire

// ===== verif/brs_host_model.sv
// Host side model issuing single byte accesses
`default_nettype none
module brs_host_model (
  // Clock
  input  wire logic       mclk,
  // Byte access toward the block
  output var  logic       acc_valid,
  output var  logic       acc_write,
  output var  logic       acc_seq,
  output var  logic [7:0] acc_addr,
  output var  logic [7:0] acc_wdata,
  output var  logic       acc_spi,
  output var  logic       acc_done
);
  timeunit 1ns;
  timeprecision 1ps;
  initial {acc_valid, acc_write, acc_seq, acc_addr, acc_wdata, acc_spi, acc_done} = '0;
  // Held across one taking edge; released lines flip so stale values never match
  task automatic op(input logic v, w, s, dn, input logic [7:0] a, d);
    @(posedge mclk);
    #1;
    {acc_valid, acc_write, acc_seq, acc_done, acc_addr, acc_wdata} = {v, w, s, dn, a, d};
    @(posedge mclk);
    #1;
    {acc_valid, acc_done, acc_addr, acc_wdata} = {2'h0, ~a, ~d};
  endtask
  // Link mapping is a level; change it only between accesses
  task automatic link_mode(input logic spi);
    @(posedge mclk);
    #1;
    acc_spi = spi;
  endtask
endmodule
`default_nettype wire

// ===== verif/tb_brs_regs.sv
// Self-checking bench for the converter settings register block
`default_nettype none
module tb_brs_regs;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, resetn, acc_valid, acc_write, acc_seq, acc_spi, acc_done, rd_valid, rd_hit;
  logic        conv_a_fall_off, conv_a_rise_instant, conv_a_force_pwm, conv_a_by_vreg;
  logic        conv_a_shedding_on, conv_b_fall_off, conv_b_rise_instant, conv_b_force_pwm;
  logic        conv_b_by_vreg, conv_b_shedding_on, conv_b_two_phase;
  logic [1:0]  conv_a_phases_eff;
  logic        repeated_write;
  logic [2:0]  reg_page;
  logic [3:0]  conv_a_current_cap, conv_b_current_cap;
  logic [6:0]  otp_vceil_a;
  logic [7:0]  acc_addr, acc_wdata, rd_data, conv_a_fall_qmv, conv_a_rise_qmv;
  logic [7:0]  conv_b_fall_qmv, conv_b_rise_qmv;
  logic [10:0] conv_a_vceil_mv;
  logic [12:0] conv_a_ilim_ma, conv_b_ilim_ma;
  logic [19:0] cv [2];
  int          bad_count = 0, n_checks = 0, cyc = 0;
  // Rates in quarter mV/us per ramp code
  localparam logic [7:0] RT [8] = '{8'h05, 8'h0a, 8'h14, 8'h28, 8'h50, 8'h78, 8'ha0, 8'h00};
  // Address, write data, read-back, hit
  localparam logic [24:0] ROWS [7] = '{{8'h80, 8'h78, 8'h40, 1'b1}, {8'h80, 8'h00, 8'h00, 1'b1},
    {8'hd0, 8'hf0, 8'hf0, 1'b1}, {8'hd3, 8'hff, 8'h1f, 1'b1}, {8'hd1, 8'h9e, 8'h9e, 1'b1},
    {8'hd5, 8'hff, 8'h55, 1'b1}, {8'h10, 8'h33, 8'h00, 1'b0}};
  assign cv[0] = {conv_a_fall_qmv, conv_a_rise_qmv, conv_a_fall_off, conv_a_rise_instant,
    conv_a_force_pwm, conv_a_by_vreg};
  assign cv[1] = {conv_b_fall_qmv, conv_b_rise_qmv, conv_b_fall_off, conv_b_rise_instant,
    conv_b_force_pwm, conv_b_by_vreg};
  brs_host_model host_u (.mclk, .acc_valid, .acc_write, .acc_seq, .acc_addr, .acc_wdata, .acc_spi,
    .acc_done);
  brs_regs #(.FOUR_PHASE(0)) dut_u (.mclk, .resetn, .acc_valid, .acc_write, .acc_seq, .acc_addr,
    .acc_wdata, .acc_spi, .acc_done, .otp_vceil_a, .rd_data, .rd_valid, .rd_hit, .reg_page,
    .repeated_write, .conv_a_current_cap, .conv_a_ilim_ma, .conv_a_fall_qmv, .conv_a_fall_off,
    .conv_a_rise_qmv, .conv_a_rise_instant, .conv_a_force_pwm, .conv_a_by_vreg,
    .conv_a_shedding_on, .conv_a_phases_eff, .conv_a_vceil_mv, .conv_b_current_cap,
    .conv_b_ilim_ma, .conv_b_fall_qmv, .conv_b_fall_off, .conv_b_rise_qmv, .conv_b_rise_instant,
    .conv_b_force_pwm, .conv_b_by_vreg, .conv_b_shedding_on, .conv_b_two_phase);
  task automatic chk(input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    host_u.op(1'b1, 1'b1, 1'b0, 1'b0, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    host_u.op(1'b1, 1'b0, 1'b0, 1'b0, a, 8'h00);
  endtask
  task automatic fin();
    host_u.op(1'b0, 1'b0, 1'b0, 1'b1, 8'h00, 8'h00);
  endtask
  always #10 mclk = ~mclk;
  // Cut a hang short well past the expected hundred or so cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      end_sim();
    end
  end
  initial begin
    logic [2:0] f;
    mclk = 1'b0;
    resetn = 1'b0;
    otp_vceil_a = 7'h55;
    repeat (12) @(posedge mclk);
    #1 resetn = 1'b1;
    foreach (ROWS[r]) begin
      wr(ROWS[r][24:17], ROWS[r][16:9]);
      rd(ROWS[r][24:17]);
      chk({rd_valid, rd_hit, rd_data}, {1'b1, ROWS[r][0], ROWS[r][8:1]});
    end
    chk({conv_b_ilim_ma, conv_a_ilim_ma}, {13'h1b58, 13'h0fa0});
    chk({conv_b_current_cap, conv_a_current_cap}, 8'hf0);
    chk({conv_b_shedding_on, conv_a_shedding_on, conv_b_two_phase, conv_a_phases_eff,
      conv_a_vceil_mv}, {3'h7, 2'h1, 11'h47e});
    // Every ramp and mode code on both converters, rise code complemented
    for (int i = 0; i < 16; i++) begin
      f = i[2:0];
      wr(8'hd1 + 8'(i[3]), {f, ~f, f[1:0]});
      chk(cv[i[3]], {RT[f], RT[~f], f == 3'h7, ~f == 3'h7, f[1:0] == 2'h2, f[1:0] == 2'h0});
    end
    // Mid-run reset clears settings without waiting for an edge
    @(posedge mclk);
    #1 resetn = 1'b0;
    #1 chk({reg_page, conv_a_ilim_ma, conv_a_by_vreg, rd_valid, conv_a_vceil_mv},
      {3'h0, 13'h0fa0, 1'b1, 1'b0, 11'h12c});
    @(posedge mclk);
    #1 resetn = 1'b1;
    // Continuation byte refused in repeated style, taken in page style
    for (int s = 1; s >= 0; s--) begin
      wr(8'h80, {1'b0, s[0], 6'h00});
      chk(repeated_write, s[0]);
      wr(8'hd1, 8'h00);
      wr(8'hd0, 8'h11);
      host_u.op(1'b1, 1'b1, 1'b1, 1'b0, 8'h00, 8'h22);
      rd(8'hd1);
      chk(rd_data, s ? 8'h00 : 8'h22);
    end
    // Upper page hides high addresses; a finished access returns the page
    wr(8'h80, 8'h82);
    rd(8'hd0);
    chk({reg_page, rd_hit, rd_data}, {3'h2, 9'h000});
    fin();
    chk(reg_page, 3'h0);
    // SPI page 001 reaches the block, a reserved code answers nothing
    wr(8'h80, 8'h01);
    host_u.link_mode(1'b1);
    rd(8'h50);
    chk({rd_hit, rd_data}, {1'b1, 8'h11});
    wr(8'h00, 8'h83);
    rd(8'h50);
    chk({rd_hit, rd_data}, 9'h000);
    fin();
    chk(reg_page, 3'h0);
    end_sim();
  end
endmodule
`default_nettype wire
